/* include/vic_pkg.sv */
// Package with constants for the vectored interrupt control block
package vic_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 4;
  localparam int NUM_SRC = 9;
  localparam int NUM_GRP = 7;
  // Digit offsets of the interrupt control bits
  localparam logic [9:0] OFS_CTL0 = 10'h000;
  localparam logic [9:0] OFS_CTL1 = 10'h001;
  localparam logic [9:0] OFS_CTL2 = 10'h002;
  localparam logic [9:0] OFS_CTL3 = 10'h003;
  localparam logic [9:0] OFS_CTL4 = 10'h022;
  localparam logic [9:0] OFS_CTL5 = 10'h023;
  localparam logic [9:0] OFS_EVT_STAT = 10'h030;
  localparam logic [9:0] OFS_EVT_MASK = 10'h031;
  localparam logic [9:0] OFS_SP_LO = 10'h032;
  // Field positions
  localparam int POS_IE = 0;
  localparam int POS_SRC0_FLAG = 1;
  localparam int POS_SRC0_MASK = 2;
  localparam int POS_PAIR_FLAG = 0;
  localparam int POS_PAIR_MASK = 1;
  localparam int POS_EV_ACK = 0;
  localparam int POS_EV_STOP = 1;
  localparam int POS_EV_HELD = 2;
  // Reset values
  localparam logic RST_IE = 1'b0;
  localparam logic RST_FLAG = 1'b0;
  localparam logic RST_MASK = 1'b1;
  localparam logic [9:0] RST_SP = 10'h3ff;
  localparam logic [2:0] RST_EVT_MASK = 3'h7;
  localparam logic [9:0] SP_STEP = 10'h004;
  localparam logic [3:0] SP_FIXED = 4'hf;
  // Vector addresses by priority group, 1 to 7
  localparam logic [13:0] VEC_RESET = 14'h0000;
  localparam logic [13:0] VEC_EXT0 = 14'h0002;
  localparam logic [13:0] VEC_EXT1 = 14'h0004;
  localparam logic [13:0] VEC_TMR_A = 14'h0006;
  localparam logic [13:0] VEC_EXT2 = 14'h0008;
  localparam logic [13:0] VEC_TMR_C = 14'h000a;
  localparam logic [13:0] VEC_TMR_D = 14'h000c;
  localparam logic [13:0] VEC_SERIAL = 14'h000e;
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int INSTR_CYCLE_NS = 80;
  localparam int INSTR_CYCLES = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_FINISH,
    SEQ_SAVE,
    SEQ_JUMP
  } vic_seq_t;
endpackage

/* src/vic_src_cell.sv */
// One interrupt source: request flag and mask bit
`timescale 1ns/100ps
`default_nettype none
module vic_src_cell (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic set_evt,
  input wire logic flag_clr,
  input wire logic mask_wr,
  input wire logic mask_val,
  output var logic flag_ff,
  output var logic mask_ff
);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flag_ff <= vic_pkg::RST_FLAG;
    end else if (set_evt) begin
      flag_ff <= 1'b1;
    end else if (flag_clr) begin
      flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_ff <= vic_pkg::RST_MASK;
    end else if (mask_wr) begin
      mask_ff <= mask_val;
    end
  end

  chk_flag_no_swset: assert property (@(posedge ref_clk) disable iff (rst)
    !flag_ff && !set_evt |=> !flag_ff) else $error("Request flag set without event");
  chk_flag_sticky_hold: assert property (@(posedge ref_clk) disable iff (rst)
    flag_ff && !flag_clr |=> flag_ff) else $error("Request flag dropped without clear");
endmodule
`default_nettype wire

/* src/vic_top.sv */
// Vectored interrupt controller with entry sequencer and stack pointer
`timescale 1ns/100ps
`default_nettype none
module vic_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ext_request_0,
  input wire logic ext_request_1,
  input wire logic ext_request_2,
  input wire logic ext_request_3,
  input wire logic ext_request_4,
  input wire logic tmr_a_event,
  input wire logic tmr_c_event,
  input wire logic tmr_d_event,
  input wire logic serial_event,
  input wire logic stop_release_pin,
  input wire logic stop_mode,
  input wire logic call_push,
  input wire logic ret_pop,
  input wire logic [9:0] addr,
  input wire logic [3:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output var logic [3:0] rdata_ff,
  output var logic irq_ack_ff,
  output var logic finish_ff,
  output var logic ctx_push_ff,
  output var logic pc_load_ff,
  output var logic [13:0] vector_ff,
  output var logic [9:0] stack_pointer_reg_ff,
  output var logic stop_release_ff,
  output var logic global_irq_enable_ff,
  output var logic irq_ff
);
  logic [8:0] src_evt;
  logic [8:0] flag;
  logic [8:0] irq_mask_bit;
  logic [8:0] pend;
  logic [6:0] grp_pend;
  logic [5:0] dig_wr;
  logic [13:0] nxt_vector;
  logic any_grp;
  logic accept;
  logic [1:0] div_ff;
  logic cycle_en_ff;
  vic_pkg::vic_seq_t state_ff;
  vic_pkg::vic_seq_t nxt_state;
  logic [2:0] evt_stat_ff;
  logic [2:0] evt_mask_ff;
  logic [2:0] evt_now;
  logic [3:0] nxt_rdata;

  assign src_evt = {serial_event, ext_request_4, tmr_d_event, ext_request_3, tmr_c_event,
    ext_request_2, tmr_a_event, ext_request_1, ext_request_0};

  assign dig_wr[0] = wr && (addr == vic_pkg::OFS_CTL0);
  assign dig_wr[1] = wr && (addr == vic_pkg::OFS_CTL1);
  assign dig_wr[2] = wr && (addr == vic_pkg::OFS_CTL2);
  assign dig_wr[3] = wr && (addr == vic_pkg::OFS_CTL3);
  assign dig_wr[4] = wr && (addr == vic_pkg::OFS_CTL4);
  assign dig_wr[5] = wr && (addr == vic_pkg::OFS_CTL5);

  vic_src_cell u_src0 (
    .ref_clk(ref_clk),
    .rst(rst),
    .set_evt(src_evt[0]),
    .flag_clr(dig_wr[0] && !wdata[vic_pkg::POS_SRC0_FLAG]),
    .mask_wr(dig_wr[0]),
    .mask_val(wdata[vic_pkg::POS_SRC0_MASK]),
    .flag_ff(flag[0]),
    .mask_ff(irq_mask_bit[0])
  );

  // Sources 1 to 8 sit two to a digit
  for (genvar s = 1; s < vic_pkg::NUM_SRC; s++) begin : g_src
    localparam int DIG = 1 + (s - 1) / 2;
    localparam int OFS = 2 * ((s - 1) % 2);
    vic_src_cell u_src (
      .ref_clk(ref_clk),
      .rst(rst),
      .set_evt(src_evt[s]),
      .flag_clr(dig_wr[DIG] && !wdata[OFS + vic_pkg::POS_PAIR_FLAG]),
      .mask_wr(dig_wr[DIG]),
      .mask_val(wdata[OFS + vic_pkg::POS_PAIR_MASK]),
      .flag_ff(flag[s]),
      .mask_ff(irq_mask_bit[s])
    );
  end

  assign pend = flag & ~irq_mask_bit;

  assign grp_pend = {pend[8], pend[7] | pend[6], pend[5] | pend[4], pend[3:0]};
  assign any_grp = |grp_pend;

  always_comb begin
    nxt_vector = vic_pkg::VEC_SERIAL;
    if (grp_pend[0]) begin
      nxt_vector = vic_pkg::VEC_EXT0;
    end else if (grp_pend[1]) begin
      nxt_vector = vic_pkg::VEC_EXT1;
    end else if (grp_pend[2]) begin
      nxt_vector = vic_pkg::VEC_TMR_A;
    end else if (grp_pend[3]) begin
      nxt_vector = vic_pkg::VEC_EXT2;
    end else if (grp_pend[4]) begin
      nxt_vector = vic_pkg::VEC_TMR_C;
    end else if (grp_pend[5]) begin
      nxt_vector = vic_pkg::VEC_TMR_D;
    end
  end

  // Instruction cycle enable; all sequencing steps on it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_ff <= 2'h0;
      cycle_en_ff <= 1'b0;
    end else begin
      div_ff <= (div_ff == 2'(vic_pkg::INSTR_CYCLES - 1)) ? 2'h0 : div_ff + 2'h1;
      cycle_en_ff <= (div_ff == 2'(vic_pkg::INSTR_CYCLES - 1));
    end
  end

  assign accept = cycle_en_ff && (state_ff == vic_pkg::SEQ_IDLE) && any_grp && global_irq_enable_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      vic_pkg::SEQ_IDLE: begin
        if (accept) begin
          nxt_state = vic_pkg::SEQ_FINISH;
        end
      end
      vic_pkg::SEQ_FINISH: begin
        if (cycle_en_ff) begin
          nxt_state = vic_pkg::SEQ_SAVE;
        end
      end
      vic_pkg::SEQ_SAVE: begin
        if (cycle_en_ff) begin
          nxt_state = vic_pkg::SEQ_JUMP;
        end
      end
      vic_pkg::SEQ_JUMP: begin
        if (cycle_en_ff) begin
          nxt_state = vic_pkg::SEQ_IDLE;
        end
      end
      default: begin
        nxt_state = vic_pkg::SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff <= vic_pkg::SEQ_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Push in second and third cycles
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_ack_ff <= 1'b0;
      finish_ff <= 1'b0;
      ctx_push_ff <= 1'b0;
      pc_load_ff <= 1'b0;
    end else begin
      irq_ack_ff <= accept;
      finish_ff <= (nxt_state == vic_pkg::SEQ_FINISH);
      ctx_push_ff <= (nxt_state == vic_pkg::SEQ_SAVE) || (nxt_state == vic_pkg::SEQ_JUMP);
      pc_load_ff <= (nxt_state == vic_pkg::SEQ_JUMP);
    end
  end

  // Vector is frozen at accept so later requests cannot change the jump
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      vector_ff <= vic_pkg::VEC_RESET;
    end else if (accept) begin
      vector_ff <= nxt_vector;
    end
  end

  // Hardware clear beats a software write
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      global_irq_enable_ff <= vic_pkg::RST_IE;
    end else if (cycle_en_ff && state_ff == vic_pkg::SEQ_FINISH) begin
      global_irq_enable_ff <= 1'b0;
    end else if (dig_wr[0]) begin
      global_irq_enable_ff <= wdata[vic_pkg::POS_IE];
    end
  end

  // Four digits per frame; upper bits stay fixed
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stack_pointer_reg_ff <= vic_pkg::RST_SP;
    end else if (accept || (call_push && !ret_pop)) begin
      stack_pointer_reg_ff <= {vic_pkg::SP_FIXED, stack_pointer_reg_ff[5:0] - vic_pkg::SP_STEP[5:0]};
    end else if (ret_pop && !call_push) begin
      stack_pointer_reg_ff <= {vic_pkg::SP_FIXED, stack_pointer_reg_ff[5:0] + vic_pkg::SP_STEP[5:0]};
    end
  end

  // Stop release only in stop mode
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stop_release_ff <= 1'b0;
    end else begin
      stop_release_ff <= stop_release_pin && stop_mode;
    end
  end

  // Event status, write one to clear, set wins
  assign evt_now = {any_grp && !global_irq_enable_ff, stop_release_pin && stop_mode, accept};

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      evt_stat_ff <= 3'h0;
    end else if (wr && addr == vic_pkg::OFS_EVT_STAT) begin
      evt_stat_ff <= (evt_stat_ff & ~wdata[2:0]) | evt_now;
    end else begin
      evt_stat_ff <= evt_stat_ff | evt_now;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      evt_mask_ff <= vic_pkg::RST_EVT_MASK;
    end else if (wr && addr == vic_pkg::OFS_EVT_MASK) begin
      evt_mask_ff <= wdata[2:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(evt_stat_ff & ~evt_mask_ff);
    end
  end

  always_comb begin
    nxt_rdata = 4'h0;
    case (addr)
      vic_pkg::OFS_CTL0: nxt_rdata = {1'b0, irq_mask_bit[0], flag[0], global_irq_enable_ff};
      vic_pkg::OFS_CTL1: nxt_rdata = {irq_mask_bit[2], flag[2], irq_mask_bit[1], flag[1]};
      vic_pkg::OFS_CTL2: nxt_rdata = {irq_mask_bit[4], flag[4], irq_mask_bit[3], flag[3]};
      vic_pkg::OFS_CTL3: nxt_rdata = {irq_mask_bit[6], flag[6], irq_mask_bit[5], flag[5]};
      vic_pkg::OFS_CTL4: nxt_rdata = {irq_mask_bit[8], flag[8], irq_mask_bit[7], flag[7]};
      vic_pkg::OFS_CTL5: nxt_rdata = 4'h0;
      vic_pkg::OFS_EVT_STAT: nxt_rdata = {1'b0, evt_stat_ff};
      vic_pkg::OFS_EVT_MASK: nxt_rdata = {1'b0, evt_mask_ff};
      vic_pkg::OFS_SP_LO: nxt_rdata = stack_pointer_reg_ff[3:0];
      default: nxt_rdata = 4'h0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_ff <= 4'h0;
    end else begin
      rdata_ff <= rd ? nxt_rdata : 4'h0;
    end
  end

  sequence s_finish;
    finish_ff && !ctx_push_ff;
  endsequence
  sequence s_save;
    ctx_push_ff && !pc_load_ff;
  endsequence
  sequence s_jump;
    ctx_push_ff && pc_load_ff;
  endsequence

  chk_entry_seq_order: assert property (@(posedge ref_clk) disable iff (rst)
    irq_ack_ff |-> s_finish ##[1:4] s_save ##[1:4] s_jump) else $error("Entry sequence out of order");
  chk_ie_auto_clear: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(ctx_push_ff) |-> !global_irq_enable_ff) else $error("Enable not cleared in second cycle");
  chk_ack_needs_ie: assert property (@(posedge ref_clk) disable iff (rst)
    irq_ack_ff |-> $past(global_irq_enable_ff) && $past(any_grp)) else $error("Accepted while disabled");
  chk_prio_ext0_first: assert property (@(posedge ref_clk) disable iff (rst)
    irq_ack_ff && $past(pend[0]) |-> vector_ff == vic_pkg::VEC_EXT0) else $error("Wrong vector for top source");
  // Shared vector for timer D group
  chk_shared_vec_d: assert property (@(posedge ref_clk) disable iff (rst)
    irq_ack_ff && $past(grp_pend[5:0] == 6'h20) |-> vector_ff == vic_pkg::VEC_TMR_D) else $error("Shared vector wrong");
  chk_sp_step_four: assert property (@(posedge ref_clk) disable iff (rst)
    irq_ack_ff && !$past(ret_pop) |-> stack_pointer_reg_ff[5:0] == $past(stack_pointer_reg_ff[5:0]) - 6'h04)
    else $error("Stack pointer not lowered by four");
  chk_stop_ignored: assert property (@(posedge ref_clk) disable iff (rst)
    !stop_mode |=> !stop_release_ff) else $error("Stop release outside stop mode");
  chk_reset_values: assert property (@(posedge ref_clk)
    rst |=> !global_irq_enable_ff && flag == 9'h000 && irq_mask_bit == 9'h1ff) else $error("Bad reset values");
  chk_vector_stable: assert property (@(posedge ref_clk) disable iff (rst)
    ctx_push_ff |-> $stable(vector_ff)) else $error("Vector changed during entry");
endmodule
`default_nettype wire

/* bench/vic_src_model.sv */
// Request source model: registers bench requests onto the event lines one cycle later
`timescale 1ns/100ps
`default_nettype none
module vic_src_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [8:0] fire,
  output var logic [8:0] evt_ff
);
  // Nine source lines
  // Events launch from a clock edge like a real peripheral, never combinationally
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      evt_ff <= 9'h000;
    end else begin
      evt_ff <= fire;
    end
  end
endmodule
`default_nettype wire

/* bench/vic_top_tb.sv */
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module vic_top_tb;
  logic ref_clk = 0, rst = 1, stop_release_pin = 0, stop_mode = 0, call_push = 0, ret_pop = 0, wr = 0, rd = 0, rd_d = 0;
  logic [9:0] addr = 10'h000, exp_sp = 10'h3ff, stack_pointer_reg_ff;
  logic [3:0] wdata = 4'h0, rdata_ff, e_w, base;
  logic [8:0] fire = 9'h000, pm;
  wire logic [8:0] evt;
  logic irq_ack_ff, finish_ff, ctx_push_ff, pc_load_ff, stop_release_ff, global_irq_enable_ff, irq_ff;
  logic [13:0] vector_ff;
  logic [3:0] exp_q[$];
  int n_mismatch = 0, comparisons = 0, a, b;
  localparam logic [9:0] DIG [5] = '{vic_pkg::OFS_CTL0, vic_pkg::OFS_CTL1, vic_pkg::OFS_CTL2, vic_pkg::OFS_CTL3,
    vic_pkg::OFS_CTL4};
  localparam int SD [9] = '{0, 1, 1, 2, 2, 3, 3, 4, 4};
  localparam int SF [9] = '{1, 0, 2, 0, 2, 0, 2, 0, 2};
  localparam logic [13:0] VEC [9] = '{vic_pkg::VEC_EXT0, vic_pkg::VEC_EXT1, vic_pkg::VEC_TMR_A, vic_pkg::VEC_EXT2,
    vic_pkg::VEC_TMR_C, vic_pkg::VEC_TMR_C, vic_pkg::VEC_TMR_D, vic_pkg::VEC_TMR_D, vic_pkg::VEC_SERIAL};

  always #10 ref_clk = ~ref_clk;

  vic_src_model vic_src_model_inst (.ref_clk(ref_clk), .rst(rst), .fire(fire), .evt_ff(evt));
  vic_top vic_top_inst (.ref_clk(ref_clk), .rst(rst), .ext_request_0(evt[0]), .ext_request_1(evt[1]),
    .tmr_a_event(evt[2]), .ext_request_2(evt[3]), .tmr_c_event(evt[4]), .ext_request_3(evt[5]),
    .tmr_d_event(evt[6]), .ext_request_4(evt[7]), .serial_event(evt[8]), .stop_release_pin(stop_release_pin),
    .stop_mode(stop_mode), .call_push(call_push), .ret_pop(ret_pop), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata_ff(rdata_ff), .irq_ack_ff(irq_ack_ff), .finish_ff(finish_ff), .ctx_push_ff(ctx_push_ff),
    .pc_load_ff(pc_load_ff), .vector_ff(vector_ff), .stack_pointer_reg_ff(stack_pointer_reg_ff),
    .stop_release_ff(stop_release_ff), .global_irq_enable_ff(global_irq_enable_ff), .irq_ff(irq_ff));

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr_reg(input logic [9:0] a_i, input logic [3:0] d_i);
    @(posedge ref_clk);
    addr <= a_i;
    wdata <= d_i;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  // Expected read data is queued; the watcher below pairs it with the answer
  task automatic rd_reg(input logic [9:0] a_i, input logic [3:0] e_i);
    @(posedge ref_clk);
    addr <= a_i;
    rd <= 1'b1;
    exp_q.push_back(e_i);
    @(posedge ref_clk);
    rd <= 1'b0;
  endtask

  task automatic pulse(input logic [8:0] m);
    @(posedge ref_clk);
    fire <= m;
    @(posedge ref_clk);
    fire <= 9'h000;
  endtask

  // Flag bits written as one keep their value; enable goes last so masks are settled first
  task automatic set_ctl(input logic [8:0] um, input logic en);
    logic [3:0] w [5];
    w = '{4'h6 | {3'h0, en}, 4'hf, 4'hf, 4'hf, 4'hf};
    for (int i = 0; i < 9; i++) if (um[i]) w[SD[i]][SF[i] + 1] = 1'b0;
    for (int d = 4; d >= 0; d--) wr_reg(DIG[d], w[d]);
  endtask

  task automatic clr_all();
    for (int d = 0; d < 5; d++) wr_reg(DIG[d], d == 0 ? 4'h4 : 4'ha);
  endtask

  task automatic entry(input logic [13:0] v);
    int i;
    for (i = 0; i < 40 && irq_ack_ff !== 1'b1; i++) tick(1);
    // Upper stack bits are fixed, so the frame index wraps in six bits
    exp_sp = {vic_pkg::SP_FIXED, exp_sp[5:0] - vic_pkg::SP_STEP[5:0]};
    `CHK(irq_ack_ff, 1'b1)
    `CHK(vector_ff, v)
    `CHK(stack_pointer_reg_ff, exp_sp)
    `CHK({finish_ff, ctx_push_ff, global_irq_enable_ff}, 3'b101)
    tick(4);
    `CHK({finish_ff, ctx_push_ff, pc_load_ff, global_irq_enable_ff}, 4'b0100)
    tick(4);
    `CHK({ctx_push_ff, pc_load_ff}, 2'b11)
    tick(4);
    `CHK({ctx_push_ff, pc_load_ff}, 2'b00)
  endtask

  always @(posedge ref_clk) begin
    rd_d <= rd;
    if (rd_d) begin
      e_w = exp_q.pop_front();
      `CHK(rdata_ff, e_w)
    end
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Whole run needs about a thousand cycles; the limit leaves wide margin
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    results();
  end

  initial begin
    a = $urandom(32'hed36);
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    tick(1);
    `CHK({global_irq_enable_ff, stack_pointer_reg_ff, irq_ff}, {1'b0, 10'h3ff, 1'b0})
    rd_reg(DIG[0], 4'h4);
    for (int d = 1; d < 5; d++) rd_reg(DIG[d], 4'ha);
    rd_reg(vic_pkg::OFS_CTL5, 4'h0);
    rd_reg(10'h3c0, 4'h0);
    wr_reg(DIG[1], 4'hf);
    rd_reg(DIG[1], 4'ha);
    wr_reg(vic_pkg::OFS_EVT_MASK, 4'h6);
    for (int s = 0; s < 9; s++) begin
      pulse(9'h001 << s);
      set_ctl(9'h001 << s, 1'b0);
      tick(12);
      `CHK({finish_ff, ctx_push_ff}, 2'b00)
      set_ctl(9'h001 << s, 1'b1);
      entry(VEC[s]);
      if (s == 0) begin
        `CHK(irq_ff, 1'b1)
        wr_reg(vic_pkg::OFS_EVT_STAT, 4'h1);
        tick(2);
        `CHK(irq_ff, 1'b0)
        wr_reg(vic_pkg::OFS_EVT_MASK, 4'h7);
      end
      base = SD[s] == 0 ? 4'h4 : 4'ha;
      rd_reg(DIG[SD[s]], (base & ~(4'h1 << (SF[s] + 1))) | (4'h1 << SF[s]));
      clr_all();
      rd_reg(DIG[SD[s]], base);
    end
    `CHK(irq_ff, 1'b0)
    rd_reg(vic_pkg::OFS_EVT_STAT, 4'h5);
    wr_reg(vic_pkg::OFS_EVT_STAT, 4'h7);
    rd_reg(vic_pkg::OFS_EVT_STAT, 4'h0);
    for (int k = 0; k < 6; k++) begin
      a = $urandom_range(8, 0);
      b = $urandom_range(8, 0);
      if (a == b) b = (a + 1) % 9;
      pm = (9'h001 << a) | (9'h001 << b);
      pulse(pm);
      set_ctl(pm, 1'b1);
      entry(VEC[a < b ? a : b]);
      clr_all();
    end
    for (int m = 0; m < 2; m++) begin
      @(posedge ref_clk);
      stop_release_pin <= 1'b1;
      stop_mode <= m[0];
      tick(1);
      `CHK(stop_release_ff, m[0])
      @(posedge ref_clk);
      stop_release_pin <= 1'b0;
    end
    @(posedge ref_clk);
    call_push <= 1'b1;
    @(posedge ref_clk);
    call_push <= 1'b0;
    tick(1);
    `CHK(stack_pointer_reg_ff, {vic_pkg::SP_FIXED, exp_sp[5:0] - vic_pkg::SP_STEP[5:0]})
    @(posedge ref_clk);
    ret_pop <= 1'b1;
    @(posedge ref_clk);
    ret_pop <= 1'b0;
    tick(1);
    `CHK(stack_pointer_reg_ff, exp_sp)
    rd_reg(vic_pkg::OFS_SP_LO, exp_sp[3:0]);
    tick(4);
    results();
  end
endmodule
`default_nettype wire
